// >>> hdl/clock_control_pkg.sv
// Register map, field layout, reset values and encodings of the clock control block
package clock_control_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] run_config_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [7:0] sleep_config_offset = 8'h08;
  localparam logic [7:0] legacy_sleep_offset = 8'h0c;
  localparam logic [7:0] sleep_power_offset = 8'h10;
  localparam logic [7:0] sleep_periph_offset = 8'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int run_div_pos = 0;
  localparam int run_pll_pos = 6;
  localparam int run_xtal_pos = 7;
  localparam int run_src_pos = 12;
  localparam int run_int_dis_pos = 15;
  localparam int run_main_dis_pos = 16;

  localparam int stat_lock_flag_pos = 0;
  localparam int stat_lock_live_pos = 1;
  localparam int stat_sleep_pos = 2;
  localparam int stat_src_pos = 3;
  localparam int stat_pll_pos = 6;
  localparam int stat_main_en_pos = 7;
  localparam int stat_int_en_pos = 8;
  localparam int stat_cfg_err_pos = 9;

  localparam int slp_div_pos = 0;
  localparam int slp_src_pos = 10;
  localparam int slp_int_pd_pos = 13;
  localparam int slp_main_pd_pos = 14;

  localparam int leg_div_pos = 0;
  localparam int leg_src_pos = 6;
  localparam int leg_int_pd_pos = 9;

  localparam int pwr_flash_pos = 0;
  localparam int pwr_sram_stby_pos = 1;
  localparam int pwr_sram_low_pos = 2;
  localparam int pwr_ldo_pos = 3;
  localparam int pwr_temp_pos = 4;
  localparam int pwr_gate_pos = 5;

  // ----------------------------------------
  // Sizes and encodings
  // ----------------------------------------
  localparam int num_periph = 8;
  localparam logic [2:0] source_main_oscillator = 3'h0;
  localparam logic [2:0] source_precision_internal = 3'h1;
  localparam logic [2:0] source_internal_quarter = 3'h2;
  localparam logic [2:0] source_low_freq_internal = 3'h3;
  localparam logic [2:0] source_hibernation_osc = 3'h4;

  // Crystal list index 0..20 from 4 MHz up to 25 MHz; index 3 is 5 MHz
  localparam logic [4:0] crystal_code_5mhz = 5'h03;
  localparam logic [4:0] crystal_code_max = 5'h14;

  localparam logic [1:0] sram_full = 2'h0;
  localparam logic [1:0] sram_standby = 2'h1;
  localparam logic [1:0] sram_lowest = 2'h2;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [5:0] run_div_reset = 6'h00;
  localparam logic [4:0] crystal_reset = 5'h03;
  localparam logic [2:0] run_src_reset = 3'h1;
  localparam logic [9:0] slp_div_reset = 10'h000;
  localparam logic [2:0] slp_src_reset = 3'h1;
  localparam logic [num_periph-1:0] periph_mask_reset = 8'h00;

  typedef enum logic [1:0] {
    st_run = 2'b01,
    st_sleep = 2'b10
  } mode_t;

endpackage : clock_control_pkg

// >>> hdl/system_clock_control.sv
// Run-mode and deep-sleep system clock control with a Wishbone register slave
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - Run divisor 1 to 64.
// - Loop output or oscillator direct, exclusive.
// - Crystal codes 4 to 25 MHz; below 5 MHz refuses loop.
// - Five run sources; hibernation needs unit enabled.
// - Separate precision and main oscillator disables.
// - Disable of the running oscillator ignored.
// - Loop needs main path and matching crystal.
// - Sticky lock flag, write-one clear.
// - Sleep gates unmarked peripherals only with auto gating.
// - Sleep divisor 1 to 1024.
// - Four sleep sources; hibernation needs unit enabled.
// - Legacy sleep code, divisor 1 to 64 plus source.
// - Sleep powers precision oscillator down unless needed.
// - Sleep powers main oscillator down unless needed.
// - Sleep flash full or reduced power.
// - Sleep SRAM full, standby or lowest.
// - Sleep regulator and temperature sensor low power.
module system_clock_control
  import clock_control_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic deep_sleep_request,
  input wire logic multiplier_loop_locked,
  input wire logic hibernation_enabled,
  output logic system_clock_tick,
  output logic [2:0] system_source,
  output logic clock_from_multiplier_loop,
  output logic multiplier_loop_power,
  output logic [4:0] crystal_frequency_code,
  output logic main_osc_enable,
  output logic precision_internal_osc_enable,
  output logic [num_periph-1:0] periph_clock_enable,
  output logic deep_sleep_active,
  output logic sleep_flash_reduced,
  output logic [1:0] sleep_sram_state,
  output logic sleep_regulator_state,
  output logic sleep_tempsense_reduced
);

  typedef struct packed {
    logic [5:0] run_divider_code;
    logic use_loop;
    logic [4:0] crystal;
    logic [2:0] run_source;
    logic internal_osc_disable;
    logic main_osc_disable;
    logic [9:0] sleep_divider_code;
    logic [2:0] sleep_source_select;
    logic sleep_internal_osc_powerdown;
    logic sleep_main_osc_powerdown;
    logic flash_reduced;
    logic sram_stby;
    logic sram_low;
    logic regulator_sleep;
    logic tempsense_reduced;
    logic auto_gating;
    logic [num_periph-1:0] sleep_mask;
    logic lock_flag;
    logic lock_seen;
    logic cfg_error;
    mode_t mode;
    logic ack;
    logic [31:0] rdata;
    logic [9:0] count;
    logic tick;
    logic [2:0] out_source;
    logic out_loop;
    logic out_main_en;
    logic out_int_en;
    logic [num_periph-1:0] out_periph;
    logic out_flash;
    logic [1:0] out_sram;
    logic out_ldo;
    logic out_temp;
  } state_t;

  state_t cur;
  state_t next_cur;

  // ----------------------------------------
  // Effective clock selection
  // ----------------------------------------
  logic loop_ok;
  logic [2:0] run_src_eff;
  logic [2:0] sleep_src_eff;
  logic in_sleep;
  logic [9:0] div_eff;
  logic main_needed;
  logic int_needed;
  logic main_on;
  logic int_on;
  logic [num_periph-1:0] periph_next;

  assign in_sleep = (cur.mode == st_sleep);

  always_comb begin
    // Unavailable hibernation falls back to precision
    if (cur.run_source == source_hibernation_osc && !hibernation_enabled) begin
      run_src_eff = source_precision_internal;
    end else begin
      run_src_eff = cur.run_source;
    end
    if (cur.sleep_source_select == source_hibernation_osc && !hibernation_enabled) begin
      sleep_src_eff = source_precision_internal;
    end else begin
      sleep_src_eff = cur.sleep_source_select;
    end
  end

  // Loop refused unless main path and crystal at or above 5 MHz
  assign loop_ok = cur.use_loop && (cur.run_source == source_main_oscillator)
                   && (cur.crystal >= crystal_code_5mhz);

  always_comb begin
    if (in_sleep) begin
      div_eff = cur.sleep_divider_code;
      main_needed = (sleep_src_eff == source_main_oscillator);
      int_needed = (sleep_src_eff == source_precision_internal);
      // Sleep powerdown only where sleep does not need the oscillator
      main_on = main_needed || (!cur.sleep_main_osc_powerdown && !cur.main_osc_disable);
      int_on = int_needed || (!cur.sleep_internal_osc_powerdown && !cur.internal_osc_disable);
    end else begin
      div_eff = {4'h0, cur.run_divider_code};
      main_needed = (run_src_eff == source_main_oscillator) || loop_ok;
      int_needed = (run_src_eff == source_precision_internal) || (run_src_eff == source_internal_quarter);
      // Disable of the running source is ignored
      main_on = main_needed || !cur.main_osc_disable;
      int_on = int_needed || !cur.internal_osc_disable;
    end
  end

  // ----------------------------------------
  // Peripheral clock gating
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < num_periph; gi = gi + 1) begin : g_periph
      assign periph_next[gi] = !in_sleep || !cur.auto_gating || cur.sleep_mask[gi];
    end
  endgenerate

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------
  logic [31:0] read_value;
  logic bus_req;
  logic wr;

  assign bus_req = wb_cyc_i && wb_stb_i && !cur.ack;
  assign wr = bus_req && wb_we_i;

  always_comb begin
    read_value = 32'h0000_0000;
    case (wb_adr_i)
      run_config_offset: begin
        read_value[run_div_pos +: 6] = cur.run_divider_code;
        read_value[run_pll_pos] = cur.use_loop;
        read_value[run_xtal_pos +: 5] = cur.crystal;
        read_value[run_src_pos +: 3] = cur.run_source;
        read_value[run_int_dis_pos] = cur.internal_osc_disable;
        read_value[run_main_dis_pos] = cur.main_osc_disable;
      end
      status_offset: begin
        read_value[stat_lock_flag_pos] = cur.lock_flag;
        read_value[stat_lock_live_pos] = cur.lock_seen;
        read_value[stat_sleep_pos] = in_sleep;
        read_value[stat_src_pos +: 3] = cur.out_source;
        read_value[stat_pll_pos] = cur.out_loop;
        read_value[stat_main_en_pos] = cur.out_main_en;
        read_value[stat_int_en_pos] = cur.out_int_en;
        read_value[stat_cfg_err_pos] = cur.cfg_error;
      end
      sleep_config_offset: begin
        read_value[slp_div_pos +: 10] = cur.sleep_divider_code;
        read_value[slp_src_pos +: 3] = cur.sleep_source_select;
        read_value[slp_int_pd_pos] = cur.sleep_internal_osc_powerdown;
        read_value[slp_main_pd_pos] = cur.sleep_main_osc_powerdown;
      end
      legacy_sleep_offset: begin
        read_value[leg_div_pos +: 6] = cur.sleep_divider_code[5:0];
        read_value[leg_src_pos +: 3] = cur.sleep_source_select;
        read_value[leg_int_pd_pos] = cur.sleep_internal_osc_powerdown;
      end
      sleep_power_offset: begin
        read_value[pwr_flash_pos] = cur.flash_reduced;
        read_value[pwr_sram_stby_pos] = cur.sram_stby;
        read_value[pwr_sram_low_pos] = cur.sram_low;
        read_value[pwr_ldo_pos] = cur.regulator_sleep;
        read_value[pwr_temp_pos] = cur.tempsense_reduced;
        read_value[pwr_gate_pos] = cur.auto_gating;
      end
      sleep_periph_offset: begin
        read_value[num_periph-1:0] = cur.sleep_mask;
      end
      default: begin
        read_value = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [2:0] wsrc;
  logic [4:0] wxtal;

  always_comb begin
    next_cur = cur;
    wsrc = 3'h0;
    wxtal = 5'h00;
    next_cur.ack = bus_req;
    if (bus_req) begin
      next_cur.rdata = read_value;
    end

    // Register writes; byte lanes honoured per field byte
    if (wr) begin
      case (wb_adr_i)
        run_config_offset: begin
          if (wb_sel_i[0]) begin
            next_cur.run_divider_code = wb_dat_i[run_div_pos +: 6];
            next_cur.use_loop = wb_dat_i[run_pll_pos];
          end
          if (wb_sel_i[1]) begin
            wxtal = wb_dat_i[run_xtal_pos +: 5];
            wsrc = wb_dat_i[run_src_pos +: 3];
            // Codes outside the lists are refused without setting cfg_error
            if (wxtal <= crystal_code_max) begin
              next_cur.crystal = wxtal;
            end
            if (wsrc <= source_hibernation_osc) begin
              next_cur.run_source = wsrc;
            end
            next_cur.internal_osc_disable = wb_dat_i[run_int_dis_pos];
          end
          if (wb_sel_i[2]) begin
            next_cur.main_osc_disable = wb_dat_i[run_main_dis_pos];
          end
        end
        sleep_config_offset: begin
          if (wb_sel_i[0]) begin
            next_cur.sleep_divider_code[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            next_cur.sleep_divider_code[9:8] = wb_dat_i[9:8];
            wsrc = wb_dat_i[slp_src_pos +: 3];
            // Quarter-rate internal is not a deep-sleep source
            if (wsrc <= source_hibernation_osc && wsrc != source_internal_quarter) begin
              next_cur.sleep_source_select = wsrc;
            end
            next_cur.sleep_internal_osc_powerdown = wb_dat_i[slp_int_pd_pos];
            next_cur.sleep_main_osc_powerdown = wb_dat_i[slp_main_pd_pos];
          end
        end
        legacy_sleep_offset: begin
          if (wb_sel_i[0]) begin
            next_cur.sleep_divider_code = {4'h0, wb_dat_i[leg_div_pos +: 6]};
          end
          if (wb_sel_i[1]) begin
            wsrc = wb_dat_i[leg_src_pos +: 3];
            if (wsrc <= source_hibernation_osc && wsrc != source_internal_quarter) begin
              next_cur.sleep_source_select = wsrc;
            end
            next_cur.sleep_internal_osc_powerdown = wb_dat_i[leg_int_pd_pos];
          end
        end
        sleep_power_offset: begin
          if (wb_sel_i[0]) begin
            next_cur.flash_reduced = wb_dat_i[pwr_flash_pos];
            next_cur.sram_stby = wb_dat_i[pwr_sram_stby_pos];
            next_cur.sram_low = wb_dat_i[pwr_sram_low_pos];
            next_cur.regulator_sleep = wb_dat_i[pwr_ldo_pos];
            next_cur.tempsense_reduced = wb_dat_i[pwr_temp_pos];
            next_cur.auto_gating = wb_dat_i[pwr_gate_pos];
          end
        end
        sleep_periph_offset: begin
          if (wb_sel_i[0]) begin
            next_cur.sleep_mask = wb_dat_i[num_periph-1:0];
          end
        end
        status_offset: begin
          // Write-one clears; a same-cycle set below still wins
          if (wb_sel_i[0] && wb_dat_i[stat_lock_flag_pos]) begin
            next_cur.lock_flag = 1'b0;
          end
          if (wb_sel_i[1] && wb_dat_i[stat_cfg_err_pos]) begin
            next_cur.cfg_error = 1'b0;
          end
        end
        default: begin
          next_cur.ack = bus_req;
        end
      endcase
    end

    // Lock edge sets the sticky flag
    next_cur.lock_seen = multiplier_loop_locked;
    if (multiplier_loop_locked && !cur.lock_seen) begin
      next_cur.lock_flag = 1'b1;
    end
    if ((cur.use_loop && !loop_ok) || (cur.run_source == source_hibernation_osc && !hibernation_enabled)) begin
      next_cur.cfg_error = 1'b1;
    end

    // Run and deep-sleep mode sequencing
    case (cur.mode)
      st_run: begin
        if (deep_sleep_request) begin
          next_cur.mode = st_sleep;
        end
      end
      st_sleep: begin
        if (!deep_sleep_request) begin
          next_cur.mode = st_run;
        end
      end
      default: begin
        next_cur.mode = st_run;
      end
    endcase

    // Divider: one tick every div_eff+1 reference cycles; restarts on mode change
    if (cur.count >= div_eff || next_cur.mode != cur.mode) begin
      next_cur.count = 10'h000;
      next_cur.tick = (cur.count >= div_eff);
    end else begin
      next_cur.count = cur.count + 10'h001;
      next_cur.tick = 1'b0;
    end

    // Registered outputs
    next_cur.out_source = in_sleep ? sleep_src_eff : run_src_eff;
    next_cur.out_loop = !in_sleep && loop_ok;
    next_cur.out_main_en = main_on;
    next_cur.out_int_en = int_on;
    next_cur.out_periph = periph_next;
    next_cur.out_flash = in_sleep && cur.flash_reduced;
    if (!in_sleep) begin
      next_cur.out_sram = sram_full;
    end else if (cur.sram_low) begin
      next_cur.out_sram = sram_lowest;
    end else if (cur.sram_stby) begin
      next_cur.out_sram = sram_standby;
    end else begin
      next_cur.out_sram = sram_full;
    end
    next_cur.out_ldo = in_sleep && cur.regulator_sleep;
    next_cur.out_temp = in_sleep && cur.tempsense_reduced;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
      cur.run_divider_code <= run_div_reset;
      cur.crystal <= crystal_reset;
      cur.run_source <= run_src_reset;
      cur.sleep_divider_code <= slp_div_reset;
      cur.sleep_source_select <= slp_src_reset;
      cur.sleep_mask <= periph_mask_reset;
      cur.mode <= st_run;
      cur.out_source <= run_src_reset;
      cur.out_main_en <= 1'b1;
      cur.out_int_en <= 1'b1;
      cur.out_periph <= '1;
    end else begin
      cur <= next_cur;
    end
  end

  assign wb_dat_o = cur.rdata;
  assign wb_ack_o = cur.ack;
  assign system_clock_tick = cur.tick;
  assign system_source = cur.out_source;
  assign clock_from_multiplier_loop = cur.out_loop;
  assign multiplier_loop_power = cur.out_loop;
  assign crystal_frequency_code = cur.crystal;
  assign main_osc_enable = cur.out_main_en;
  assign precision_internal_osc_enable = cur.out_int_en;
  assign periph_clock_enable = cur.out_periph;
  assign deep_sleep_active = in_sleep;
  assign sleep_flash_reduced = cur.out_flash;
  assign sleep_sram_state = cur.out_sram;
  assign sleep_regulator_state = cur.out_ldo;
  assign sleep_tempsense_reduced = cur.out_temp;

endmodule : system_clock_control

`default_nettype wire

// >>> tb/system_clock_control_assertions.sv
// Concurrent checks on the ports of the clock control block
`timescale 1ns/1ns
`default_nettype none
module system_clock_control_assertions
  import clock_control_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic deep_sleep_request,
  input wire logic [2:0] system_source,
  input wire logic clock_from_multiplier_loop,
  input wire logic multiplier_loop_power,
  input wire logic [4:0] crystal_frequency_code,
  input wire logic main_osc_enable,
  input wire logic precision_internal_osc_enable,
  input wire logic [num_periph-1:0] periph_clock_enable,
  input wire logic deep_sleep_active,
  input wire logic sleep_flash_reduced,
  input wire logic [1:0] sleep_sram_state,
  input wire logic sleep_regulator_state,
  input wire logic sleep_tempsense_reduced
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence bus_taken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence sleep_reach; deep_sleep_active ##1 !clock_from_multiplier_loop; endsequence
  sequence wake_reach; !deep_sleep_active ##1 (sleep_sram_state == sram_full); endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ack_after_take: assert property (bus_taken |=> wb_ack_o)
    else $error("no ack");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  a_loop_main_only: assert property (clock_from_multiplier_loop |-> system_source == source_main_oscillator && $past(crystal_frequency_code) >= crystal_code_5mhz)
    else $error("loop misuse");
  a_loop_power_pair: assert property (clock_from_multiplier_loop == multiplier_loop_power)
    else $error("loop power mismatch");
  a_sleep_entry: assert property ($rose(deep_sleep_request) |=> sleep_reach)
    else $error("sleep entry");
  a_sleep_exit: assert property ($fell(deep_sleep_request) |=> wake_reach)
    else $error("sleep exit");
  a_run_power_full: assert property (!deep_sleep_active && !$past(deep_sleep_active) |-> !sleep_flash_reduced && sleep_sram_state == sram_full && !sleep_regulator_state && !sleep_tempsense_reduced)
    else $error("sleep power in run");
  a_run_periph_all: assert property (!deep_sleep_active && !$past(deep_sleep_active) |-> periph_clock_enable == {num_periph{1'b1}})
    else $error("gated in run");
  a_running_main_on: assert property (system_source == source_main_oscillator |-> main_osc_enable)
    else $error("running main off");
  a_running_int_on: assert property (system_source == source_precision_internal |-> precision_internal_osc_enable)
    else $error("running precision off");
endmodule : system_clock_control_assertions

bind system_clock_control system_clock_control_assertions i_chk (
  .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .deep_sleep_request(deep_sleep_request), .system_source(system_source),
  .clock_from_multiplier_loop(clock_from_multiplier_loop), .multiplier_loop_power(multiplier_loop_power),
  .crystal_frequency_code(crystal_frequency_code), .main_osc_enable(main_osc_enable),
  .precision_internal_osc_enable(precision_internal_osc_enable), .periph_clock_enable(periph_clock_enable),
  .deep_sleep_active(deep_sleep_active), .sleep_flash_reduced(sleep_flash_reduced),
  .sleep_sram_state(sleep_sram_state), .sleep_regulator_state(sleep_regulator_state),
  .sleep_tempsense_reduced(sleep_tempsense_reduced));
`default_nettype wire

// >>> tb/tb_system_clock_control.sv
// Self-checking bench of the clock control block over Wishbone
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module tb_system_clock_control;
  import clock_control_pkg::*;
  logic ref_clk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, deep_sleep_request = 0, multiplier_loop_locked = 0, hibernation_enabled = 0;
  logic system_clock_tick, clock_from_multiplier_loop, multiplier_loop_power, main_osc_enable;
  logic precision_internal_osc_enable, deep_sleep_active, sleep_flash_reduced, sleep_regulator_state;
  logic sleep_tempsense_reduced;
  logic [2:0] system_source;
  logic [4:0] crystal_frequency_code;
  logic [num_periph-1:0] periph_clock_enable;
  logic [1:0] sleep_sram_state;
  int failures = 0, total_checks = 0, g;
  always #5 ref_clk = ~ref_clk;
  system_clock_control i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .deep_sleep_request(deep_sleep_request), .multiplier_loop_locked(multiplier_loop_locked),
    .hibernation_enabled(hibernation_enabled), .system_clock_tick(system_clock_tick),
    .system_source(system_source), .clock_from_multiplier_loop(clock_from_multiplier_loop),
    .multiplier_loop_power(multiplier_loop_power), .crystal_frequency_code(crystal_frequency_code),
    .main_osc_enable(main_osc_enable), .precision_internal_osc_enable(precision_internal_osc_enable),
    .periph_clock_enable(periph_clock_enable), .deep_sleep_active(deep_sleep_active),
    .sleep_flash_reduced(sleep_flash_reduced), .sleep_sram_state(sleep_sram_state),
    .sleep_regulator_state(sleep_regulator_state), .sleep_tempsense_reduced(sleep_tempsense_reduced));
  // ----------------------------------------
  // Bus and timing tasks
  // ----------------------------------------
  task stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = wb_dat_o;
    wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
  endtask : bus
  task settle;
    repeat (4) @(posedge ref_clk);
  endtask : settle
  // Tick period; bounded against a dead divider
  task tick_gap(output int gap);
    int n;
    n = 0;
    while (system_clock_tick !== 1'b1 && n < 3000) begin @(posedge ref_clk); n++; end
    gap = 0;
    do begin @(posedge ref_clk); gap++; end while (system_clock_tick !== 1'b1 && gap < 3000);
  endtask : tick_gap
  function automatic logic [31:0] run_w(int dv, int pl, int xt, int sr, int idis, int mdis);
    return 32'(dv) | 32'(pl) << run_pll_pos | 32'(xt) << run_xtal_pos | 32'(sr) << run_src_pos
      | 32'(idis) << run_int_dis_pos | 32'(mdis) << run_main_dis_pos;
  endfunction : run_w
  function automatic logic [31:0] slp_w(int dv, int sr, int ipd, int mpd);
    return 32'(dv) | 32'(sr) << slp_src_pos | 32'(ipd) << slp_int_pd_pos | 32'(mpd) << slp_main_pd_pos;
  endfunction : slp_w
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (50000) @(posedge ref_clk);
    failures++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1;
    settle();
    `CHK("reset source", source_precision_internal, system_source)
    `CHK("reset loop", 1'b0, clock_from_multiplier_loop)
    `CHK("reset crystal", crystal_reset, crystal_frequency_code)
    `CHK("reset periph", {num_periph{1'b1}}, periph_clock_enable)
    bus(0, run_config_offset, 0);
    `CHK("run config", run_w(0, 0, crystal_reset, run_src_reset, 0, 0), rd)
    for (int dv = 0; dv < 64; dv += 21) begin
      bus(1, run_config_offset, run_w(dv, 0, 3, 0, 0, 0));
      tick_gap(g);
      `CHK("run divisor", dv + 1, g)
    end
    bus(1, run_config_offset, run_w(0, 1, 3, 0, 0, 0));
    settle();
    `CHK("loop on", 1'b1, clock_from_multiplier_loop)
    bus(1, run_config_offset, run_w(0, 1, 2, 0, 0, 0));
    settle();
    `CHK("loop low crystal", 1'b0, clock_from_multiplier_loop)
    bus(1, run_config_offset, run_w(0, 0, 21, 0, 0, 0));
    settle();
    `CHK("crystal kept", 5'h02, crystal_frequency_code)
    bus(1, run_config_offset, run_w(0, 1, 20, 1, 0, 0));
    settle();
    `CHK("loop non main", 1'b0, clock_from_multiplier_loop)
    for (int s = 0; s < 5; s++) begin
      bus(1, run_config_offset, run_w(0, 0, 3, s, 0, 0));
      settle();
      `CHK("run source", 3'(s == 4 ? 1 : s), system_source)
    end
    hibernation_enabled <= 1;
    bus(1, run_config_offset, run_w(0, 0, 3, 4, 0, 0));
    settle();
    `CHK("hib source", source_hibernation_osc, system_source)
    bus(1, run_config_offset, run_w(0, 0, 3, 0, 1, 1));
    settle();
    `CHK("main kept", 1'b1, main_osc_enable)
    `CHK("int off", 1'b0, precision_internal_osc_enable)
    bus(1, run_config_offset, run_w(0, 0, 3, 1, 1, 1));
    settle();
    `CHK("int kept", 1'b1, precision_internal_osc_enable)
    `CHK("main off", 1'b0, main_osc_enable)
    multiplier_loop_locked <= 1;
    settle();
    multiplier_loop_locked <= 0;
    bus(0, status_offset, 0);
    `CHK("lock sticky", 1'b1, rd[stat_lock_flag_pos])
    bus(1, status_offset, 32'h1);
    bus(0, status_offset, 0);
    `CHK("lock cleared", 1'b0, rd[stat_lock_flag_pos])
    bus(1, 8'h20, 32'hffffffff);
    bus(0, 8'h20, 0);
    `CHK("unmapped", 32'h0, rd)
    bus(1, run_config_offset, run_w(0, 0, 3, 1, 0, 0));
    bus(1, sleep_config_offset, slp_w(9, 3, 1, 1));
    bus(1, sleep_power_offset, 32'h3d);
    bus(1, sleep_periph_offset, 32'h5a);
    deep_sleep_request <= 1;
    settle();
    `CHK("sleep source", source_low_freq_internal, system_source)
    `CHK("int pd", 1'b0, precision_internal_osc_enable)
    `CHK("main pd", 1'b0, main_osc_enable)
    `CHK("flash", 1'b1, sleep_flash_reduced)
    `CHK("sram low", sram_lowest, sleep_sram_state)
    `CHK("ldo temp", 2'b11, {sleep_regulator_state, sleep_tempsense_reduced})
    `CHK("gated", 8'h5a, periph_clock_enable)
    tick_gap(g);
    `CHK("sleep divisor", 10, g)
    deep_sleep_request <= 0;
    settle();
    `CHK("wake source", source_precision_internal, system_source)
    `CHK("wake int", 1'b1, precision_internal_osc_enable)
    tick_gap(g);
    `CHK("wake divisor", 1, g)
    bus(1, sleep_config_offset, slp_w(0, 1, 1, 0));
    bus(1, sleep_config_offset, slp_w(0, 2, 1, 0));
    bus(1, sleep_power_offset, 32'h02);
    deep_sleep_request <= 1;
    settle();
    `CHK("quarter refused", source_precision_internal, system_source)
    `CHK("int needed", 1'b1, precision_internal_osc_enable)
    `CHK("sram standby", sram_standby, sleep_sram_state)
    `CHK("ungated", {num_periph{1'b1}}, periph_clock_enable)
    deep_sleep_request <= 0;
    settle();
    stop_test();
  end
endmodule : tb_system_clock_control
`default_nettype wire
